// ==== rivm_pkg.sv ====
package rivm_pkg;
   localparam int unsigned PC_W = 12;
   localparam int unsigned NUM_IRQ = 25;
   localparam int unsigned IDX_W = 5;
   localparam logic [11:0] RESET_ADDR_DEFAULT = 12'h000;
   localparam logic [11:0] TABLE_START_DEFAULT = 12'h001;
   localparam logic [11:0] BOOT_RESET_ADDR_DEFAULT = 12'hc00;
   localparam logic FUSE_PROGRAMMED = 1'b0;
   localparam logic FUSE_UNPROGRAMMED = 1'b1;
   localparam logic [IDX_W-1:0] IDX_EXT_IRQ_LINE_0 = 5'h00;
   localparam logic [IDX_W-1:0] IDX_EXT_IRQ_LINE_1 = 5'h01;
   localparam logic [IDX_W-1:0] IDX_PIN_CHANGE_GROUP_0 = 5'h02;
   localparam logic [IDX_W-1:0] IDX_PIN_CHANGE_GROUP_2 = 5'h04;
   localparam logic [IDX_W-1:0] IDX_WATCHDOG = 5'h05;
   localparam logic [IDX_W-1:0] IDX_ASYNC_TIMER_MATCH_A = 5'h06;
   localparam logic [IDX_W-1:0] IDX_ASYNC_TIMER_OVERFLOW = 5'h08;
   localparam logic [IDX_W-1:0] IDX_WIDE_TIMER_CAPTURE = 5'h09;
   localparam logic [IDX_W-1:0] IDX_WIDE_TIMER_OVERFLOW = 5'h0c;
   localparam logic [IDX_W-1:0] IDX_BASE_TIMER_MATCH_A = 5'h0d;
   localparam logic [IDX_W-1:0] IDX_BASE_TIMER_OVERFLOW = 5'h0f;
   localparam logic [IDX_W-1:0] IDX_SPI_TRANSFER_DONE = 5'h10;
   localparam logic [IDX_W-1:0] IDX_USART_RX_DONE = 5'h11;
   localparam logic [IDX_W-1:0] IDX_USART_TX_DONE = 5'h13;
   localparam logic [IDX_W-1:0] IDX_ADC_DONE = 5'h14;
   localparam logic [IDX_W-1:0] IDX_EEPROM_READY = 5'h15;
   localparam logic [IDX_W-1:0] IDX_TWO_WIRE_SERIAL = 5'h17;
   localparam logic [IDX_W-1:0] IDX_FLASH_STORE_READY = 5'h18;
   typedef enum logic [2:0] {
      RIVM_ST_RESET = 3'b001,
      RIVM_ST_RUN = 3'b010,
      RIVM_ST_ACK = 3'b100
   } rivm_state_e;
endpackage : rivm_pkg

// ==== rivm_prio_enc.sv ====
`timescale 1ns/1ps
module rivm_prio_enc #(
   parameter int unsigned N = 25,
   parameter int unsigned W = 5
) (
   input wire logic [N-1:0] req_i,
   output logic any_o,
   output logic [W-1:0] idx_o
);
   // Walk downward so the lowest index wins
   always_comb begin
      any_o = 1'b0;
      idx_o = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (req_i[i]) begin
            any_o = 1'b1;
            idx_o = W'(i);
         end
      end
   end
endmodule : rivm_prio_enc

// ==== rivm_vector_map.sv ====
`timescale 1ns/1ps
// Contract
// (RL1) Unprogrammed boot fuse: every reset cause sends the PC to word 0x000.
// (RL2) External lines 0 and 1 sit at table offsets 0x001 and 0x002.
// (RL3) Pin-change groups at 0x003..0x005 in order; watchdog at 0x006.
// (RL4) Async timer match A, match B, overflow at 0x007, 0x008, 0x009.
// (RL5) Wide timer capture, match A, match B, overflow at 0x00A..0x00D.
// (RL6) Base timer match A, match B, overflow at 0x00E, 0x00F, 0x010.
// (RL7) SPI transfer done at 0x011.
// (RL8) USART receive, buffer empty, transmit done at 0x012, 0x013, 0x014.
// (RL9) ADC 0x015, EEPROM ready 0x016, comparator 0x017, two-wire 0x018.
// (RL10) Flash store ready, the last of 26 vectors, at 0x019.
// (RL11) Programmed boot fuse: reset loads the boot reset address instead of zero.
// (RL12) Relocate bit set: each vector is base offset plus boot section start.
// (RL13) Reset target follows only the fuse; table start follows only the bit.
// (RL14) Fuse value 1 means unprogrammed, 0 means programmed.
// (RL15) Software may reuse vector words when no interrupt is ever enabled.
// (RL16) Software may reuse the unused vector area when reset and table split.
// (RL17) Among pending enabled requests the lowest vector number is dispatched first.
module rivm_vector_map
   import rivm_pkg::*;
#(
   parameter logic [rivm_pkg::PC_W-1:0] BOOT_RESET_ADDR = rivm_pkg::BOOT_RESET_ADDR_DEFAULT
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic boot_reset_select_fuse_i,
   input wire logic vector_table_relocate_bit_i,
   input wire logic [rivm_pkg::NUM_IRQ-1:0] irq_req_i,
   input wire logic vec_ack_i,
   output logic reset_fetch_o,
   output logic [rivm_pkg::PC_W-1:0] reset_addr_o,
   output logic irq_valid_o,
   output logic [rivm_pkg::IDX_W-1:0] irq_index_o,
   output logic [rivm_pkg::PC_W-1:0] irq_vector_addr_o
);
   import rivm_pkg::*;

   typedef struct packed {
      rivm_state_e st;
      logic reset_fetch;
      logic [PC_W-1:0] reset_addr;
      logic irq_valid;
      logic [IDX_W-1:0] irq_index;
      logic [PC_W-1:0] irq_addr;
   } rivm_state_s;

   rivm_state_s cur_r;
   rivm_state_s cur_nxt;
   logic any_req;
   logic [IDX_W-1:0] win_idx;

   // Fuse decode is used only for the reset target; the checks read the fuse input directly
   function automatic logic fuse_programmed(input logic f);
      return f == FUSE_PROGRAMMED; // [RL14]
   endfunction : fuse_programmed

   function automatic logic [PC_W-1:0] reset_target(input logic f);
      return fuse_programmed(f) ? BOOT_RESET_ADDR : RESET_ADDR_DEFAULT; // [RL1] [RL11]
   endfunction : reset_target

   // Sources are indexed so offset = start + index; vector number = index + 2
   function automatic logic [PC_W-1:0] vec_addr(input logic relo, input logic [IDX_W-1:0] idx);
      logic [PC_W-1:0] start;
      start = relo ? PC_W'(BOOT_RESET_ADDR + TABLE_START_DEFAULT) : TABLE_START_DEFAULT; // [RL12] [RL13]
      return PC_W'(start + PC_W'(idx)); // [RL2] [RL3] [RL4] [RL5] [RL6] [RL7] [RL8] [RL9] [RL10]
   endfunction : vec_addr

   rivm_prio_enc #(
      .N(NUM_IRQ),
      .W(IDX_W)
   ) u_prio (
      .req_i(irq_req_i),
      .any_o(any_req),
      .idx_o(win_idx)
   ); // [RL17]

   always_comb begin
      cur_nxt = cur_r;
      cur_nxt.reset_fetch = 1'b0;
      case (cur_r.st)
         RIVM_ST_RESET: begin
            // Reset outranks every interrupt: announce it before any dispatch
            cur_nxt.reset_fetch = 1'b1;
            cur_nxt.reset_addr = reset_target(boot_reset_select_fuse_i); // [RL13]
            cur_nxt.st = RIVM_ST_RUN;
         end
         RIVM_ST_RUN: begin
            if (any_req) begin
               cur_nxt.irq_valid = 1'b1;
               cur_nxt.irq_index = win_idx; // [RL17]
               cur_nxt.irq_addr = vec_addr(vector_table_relocate_bit_i, win_idx);
               cur_nxt.st = RIVM_ST_ACK;
            end
         end
         RIVM_ST_ACK: begin
            // Offer held stable until the core takes it
            if (vec_ack_i) begin
               cur_nxt.irq_valid = 1'b0;
               cur_nxt.st = RIVM_ST_RUN;
            end
         end
         default: begin
            cur_nxt.st = RIVM_ST_RUN;
            cur_nxt.irq_valid = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cur_r <= '{st: RIVM_ST_RESET, reset_fetch: 1'b0, reset_addr: RESET_ADDR_DEFAULT,
                    irq_valid: 1'b0, irq_index: '0, irq_addr: TABLE_START_DEFAULT};
      end else begin
         cur_r <= cur_nxt;
      end
   end

   assign reset_fetch_o = cur_r.reset_fetch;
   assign reset_addr_o = cur_r.reset_addr;
   assign irq_valid_o = cur_r.irq_valid;
   assign irq_index_o = cur_r.irq_index;
   assign irq_vector_addr_o = cur_r.irq_addr;

   reset_zero_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL1]
      $rose(reset_fetch_o) && boot_reset_select_fuse_i && $past(boot_reset_select_fuse_i)
      |-> reset_addr_o == 12'h000)
      else $error("reset target not zero with fuse unprogrammed");

   reset_boot_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL11]
      $rose(reset_fetch_o) && !$past(boot_reset_select_fuse_i)
      |-> reset_addr_o == BOOT_RESET_ADDR)
      else $error("reset target not boot address with fuse programmed");

   ext_line_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL2]
      $rose(irq_valid_o) && irq_index_o == IDX_EXT_IRQ_LINE_1 && !$past(vector_table_relocate_bit_i)
      |-> irq_vector_addr_o == 12'h002)
      else $error("line 1 vector misplaced");

   watchdog_vec_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL3]
      $rose(irq_valid_o) && irq_index_o == IDX_WATCHDOG && !$past(vector_table_relocate_bit_i)
      |-> irq_vector_addr_o == 12'h006)
      else $error("watchdog vector misplaced");

   wide_ovf_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL5]
      $rose(irq_valid_o) && irq_index_o == IDX_WIDE_TIMER_OVERFLOW && !$past(vector_table_relocate_bit_i)
      |-> irq_vector_addr_o == 12'h00d)
      else $error("wide timer overflow vector misplaced");

   last_vec_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL10]
      $rose(irq_valid_o) && irq_index_o == IDX_FLASH_STORE_READY && !$past(vector_table_relocate_bit_i)
      |-> irq_vector_addr_o == 12'h019)
      else $error("flash store vector misplaced");

   relocate_vec_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL12]
      $rose(irq_valid_o) && $past(vector_table_relocate_bit_i)
      |-> irq_vector_addr_o == PC_W'(BOOT_RESET_ADDR + 12'h001 + PC_W'(irq_index_o)))
      else $error("relocated vector address wrong");

   lowest_wins_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL17]
      $rose(irq_valid_o) && $past(irq_req_i[0]) |-> irq_index_o == '0)
      else $error("lower vector not dispatched first");

   offer_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL17]
      irq_valid_o && !vec_ack_i |=> irq_valid_o && $stable(irq_vector_addr_o))
      else $error("vector offer dropped before ack");

   line0_vec_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL2]
      $rose(irq_valid_o) && irq_index_o == IDX_EXT_IRQ_LINE_0 && !$past(vector_table_relocate_bit_i)
      |-> irq_vector_addr_o == 12'h001)
      else $error("line 0 vector misplaced");

   pin_group_first_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL3]
      $rose(irq_valid_o) && irq_index_o == IDX_PIN_CHANGE_GROUP_0 && !$past(vector_table_relocate_bit_i)
      |-> irq_vector_addr_o == 12'h003)
      else $error("pin change group 0 vector misplaced");

   pin_group_last_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL3]
      $rose(irq_valid_o) && irq_index_o == IDX_PIN_CHANGE_GROUP_2 && !$past(vector_table_relocate_bit_i)
      |-> irq_vector_addr_o == 12'h005)
      else $error("pin change group 2 vector misplaced");

   async_match_vec_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL4]
      $rose(irq_valid_o) && irq_index_o == IDX_ASYNC_TIMER_MATCH_A && !$past(vector_table_relocate_bit_i)
      |-> irq_vector_addr_o == 12'h007)
      else $error("async timer match a vector misplaced");

   async_ovf_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL4]
      $rose(irq_valid_o) && irq_index_o == IDX_ASYNC_TIMER_OVERFLOW && !$past(vector_table_relocate_bit_i)
      |-> irq_vector_addr_o == 12'h009)
      else $error("async timer overflow vector misplaced");

   wide_capture_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL5]
      $rose(irq_valid_o) && irq_index_o == IDX_WIDE_TIMER_CAPTURE && !$past(vector_table_relocate_bit_i)
      |-> irq_vector_addr_o == 12'h00a)
      else $error("wide timer capture vector misplaced");

   base_match_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL6]
      $rose(irq_valid_o) && irq_index_o == IDX_BASE_TIMER_MATCH_A && !$past(vector_table_relocate_bit_i)
      |-> irq_vector_addr_o == 12'h00e)
      else $error("base timer match a vector misplaced");

   base_ovf_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL6]
      $rose(irq_valid_o) && irq_index_o == IDX_BASE_TIMER_OVERFLOW && !$past(vector_table_relocate_bit_i)
      |-> irq_vector_addr_o == 12'h010)
      else $error("base timer overflow vector misplaced");

   spi_done_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL7]
      $rose(irq_valid_o) && irq_index_o == IDX_SPI_TRANSFER_DONE && !$past(vector_table_relocate_bit_i)
      |-> irq_vector_addr_o == 12'h011)
      else $error("spi transfer done vector misplaced");

   usart_rx_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL8]
      $rose(irq_valid_o) && irq_index_o == IDX_USART_RX_DONE && !$past(vector_table_relocate_bit_i)
      |-> irq_vector_addr_o == 12'h012)
      else $error("usart receive vector misplaced");

   usart_tx_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL8]
      $rose(irq_valid_o) && irq_index_o == IDX_USART_TX_DONE && !$past(vector_table_relocate_bit_i)
      |-> irq_vector_addr_o == 12'h014)
      else $error("usart transmit vector misplaced");

   adc_done_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL9]
      $rose(irq_valid_o) && irq_index_o == IDX_ADC_DONE && !$past(vector_table_relocate_bit_i)
      |-> irq_vector_addr_o == 12'h015)
      else $error("adc done vector misplaced");

   eeprom_ready_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL9]
      $rose(irq_valid_o) && irq_index_o == IDX_EEPROM_READY && !$past(vector_table_relocate_bit_i)
      |-> irq_vector_addr_o == 12'h016)
      else $error("eeprom ready vector misplaced");

   two_wire_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL9]
      $rose(irq_valid_o) && irq_index_o == IDX_TWO_WIRE_SERIAL && !$past(vector_table_relocate_bit_i)
      |-> irq_vector_addr_o == 12'h018)
      else $error("two-wire vector misplaced");

   table_start_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL13]
      $rose(irq_valid_o) && !$past(vector_table_relocate_bit_i)
      |-> irq_vector_addr_o == PC_W'(12'h001 + PC_W'(irq_index_o)))
      else $error("base table start depends on more than the relocate bit");

   fetch_pulse_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL1]
      reset_fetch_o |=> !reset_fetch_o)
      else $error("reset fetch longer than one cycle");

   reset_first_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL17]
      reset_fetch_o |-> !irq_valid_o)
      else $error("vector offered alongside reset fetch");

   reset_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL13]
      !$rose(reset_fetch_o) |-> $stable(reset_addr_o))
      else $error("reset target changed between resets");
endmodule : rivm_vector_map

// ==== rivm_core_model.sv ====
`timescale 1ns/1ps
module rivm_core_model (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic irq_valid_i,
   input wire logic [2:0] delay_i,
   output logic vec_ack_o
);
   logic [2:0] wait_r;
   // Takes only offered vectors, after a chosen stall
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         vec_ack_o <= 1'b0;
         wait_r <= 3'h0;
      end else if (vec_ack_o) begin
         vec_ack_o <= 1'b0;
      end else if (irq_valid_i && wait_r >= delay_i) begin
         vec_ack_o <= 1'b1;
         wait_r <= 3'h0;
      end else if (irq_valid_i) begin
         wait_r <= wait_r + 3'h1;
      end
   end
endmodule : rivm_core_model

// ==== test_rivm_vector_map.sv ====
`timescale 1ns/1ps
module test_rivm_vector_map;
   import rivm_pkg::*;
   logic ref_clk_i = 1'b0, rst_i = 1'b1, fuse = 1'b1, reloc = 1'b0, ack, fetch, valid, prev_v = 1'b0;
   logic [24:0] req = '0;
   logic [2:0] delay = 3'h0;
   logic [11:0] raddr, vaddr;
   logic [4:0] idx;
   logic [31:0] seed = 32'hbf87;
   logic [16:0] exp_q[$];
   int err_count = 0, compares = 0;
   rivm_vector_map dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .boot_reset_select_fuse_i(fuse),
      .vector_table_relocate_bit_i(reloc), .irq_req_i(req), .vec_ack_i(ack), .reset_fetch_o(fetch),
      .reset_addr_o(raddr), .irq_valid_o(valid), .irq_index_o(idx), .irq_vector_addr_o(vaddr));
   rivm_core_model core_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .irq_valid_i(valid), .delay_i(delay),
      .vec_ack_o(ack));
   initial begin
      forever #25 ref_clk_i = ~ref_clk_i;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction : xs
   function automatic logic [4:0] lowbit(input logic [24:0] r);
      for (int i = 24; i >= 0; i--) begin
         if (r[i]) lowbit = 5'(i);
      end
   endfunction : lowbit
   task automatic check(input logic [16:0] got, input logic [16:0] exp);
      compares++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         err_count++;
      end
   endtask : check
   task automatic print_verdict;
      $display("compares=%0d err_count=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   task automatic do_reset(input logic f, input logic rl);
      @(posedge ref_clk_i);
      rst_i <= 1'b1;
      fuse <= f;
      reloc <= rl;
      repeat (6) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      @(posedge ref_clk_i);
      #1 check({fetch, raddr}, {1'b1, f ? 12'h000 : BOOT_RESET_ADDR_DEFAULT});
      @(posedge ref_clk_i);
      #1 check(17'(fetch), 17'h0);
   endtask : do_reset
   task automatic send(input logic [24:0] r);
      logic [4:0] lo;
      int n;
      lo = lowbit(r);
      n = 0;
      @(posedge ref_clk_i);
      req <= r;
      exp_q.push_back({lo, (reloc ? BOOT_RESET_ADDR_DEFAULT : 12'h000) + 12'h001 + 12'(lo)});
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1) check(17'(ack), 17'h1);
      req <= '0;
      repeat (2) @(posedge ref_clk_i);
   endtask : send
   // Compare once per offer, on its first valid cycle
   always @(posedge ref_clk_i) begin
      prev_v <= valid;
      if (valid === 1'b1 && prev_v !== 1'b1) begin
         if (exp_q.size() == 0) check({idx, vaddr}, 17'h1ffff);
         else check({idx, vaddr}, exp_q.pop_front());
      end
   end
   initial begin
      for (int k = 0; k < 4; k++) begin
         do_reset(k[1], k[0]);
         for (int i = 0; i < 35; i++) begin
            seed = xs(seed);
            delay <= seed[30:28];
            send(i < 25 ? 25'h1 << i : seed[24:0] | 25'h1000000);
         end
      end
      check(17'(exp_q.size()), 17'h0);
      print_verdict();
   end
   // Whole run needs about 1400 cycles
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      err_count++;
      print_verdict();
   end
endmodule : test_rivm_vector_map
